/* File: lds_pkg.sv */
// Package with offsets, fields and reset values of the source control bank
package lds_pkg;
	localparam logic [7:0] ADDR_DAC2_CODE   = 8'h84;
	localparam logic [7:0] ADDR_SRC_RANGE   = 8'h85;
	localparam logic [7:0] ADDR_WR_PERMIT   = 8'h86;
	localparam logic [7:0] ADDR_CONV_RESULT = 8'h87;
	localparam logic [7:0] ADDR_RSVD_LO     = 8'h88;
	localparam logic [7:0] ADDR_RSVD_HI     = 8'h8F;
	localparam logic [7:0] TABLE_ONE_BASE        = 8'h90;
	localparam logic [7:0] TABLE_TWO_BASE        = 8'hD0;
	localparam int         BIT_DAC2_SRC     = 7;
	localparam int         BIT_TABLE_TWO_SRC     = 6;
	localparam int         BIT_DAC1_SRC     = 5;
	localparam int         BIT_TABLE_ONE_SRC     = 4;
	localparam int         BIT_GEN2_FS_LO   = 2;
	localparam int         BIT_GEN1_FS_LO   = 0;
	localparam int         BIT_WEL          = 7;
	localparam logic [7:0] WEL_SET_VAL      = 8'h80;
	localparam logic [7:0] WEL_CLR_VAL      = 8'h00;
	localparam logic [7:0] RST_DAC2_CODE    = 8'h00;
	localparam logic [7:0] RST_SRC_RANGE    = 8'h00;
	localparam logic       RST_WEL          = 1'b0;
endpackage : lds_pkg

/* File: lds_regs.sv */
// Source select, range and write enable register bank
//
// Operation
// - Byte 84h holds the converter 2 direct code, kept as persist says.
// - Converter 2 takes the direct code when 85h bit 7 is set.
// - Byte 85h holds the source selects and ranges, read and written.
// - Generator 1 range picks the external resistor or an internal range.
// - Generator 2 range picks the external resistor or an internal range.
// - Generator 1 direction follows its control register 0 bit.
// - Table one row comes from the converter result or the manual row.
// - Converter 1 takes the table one row or the control register 3 byte.
// - Table two row comes from the converter result or the manual row.
// - Byte 86h holds the volatile write enable latch in bit 7.
// - Bytes 88h to 8Fh are reserved and have no function.
// - The latch resets to 0, is set by writing 80h and cleared by 00h.
// - With the latch clear a write to any byte but 86h is aborted and not acknowledged.
// - Byte 87h is read only and returns the converter result.
// - The table two row address is D0h plus the six bit row value.
`timescale 1ns/1ps
module lds_regs (
	input  wire logic       CLK_I,          // 200 MHz clock
	input  wire logic       RESETN_I,       // Async reset, active low
	input  wire logic       WR_I,           // Byte write strobe
	input  wire logic       RD_I,           // Byte read strobe
	input  wire logic [7:0] ADDR_I,         // Byte address
	input  wire logic [7:0] WDATA_I,        // Write data
	input  wire logic [7:0] ADC_I,          // Converter result
	input  wire logic [7:0] DAC1_CODE_I,    // Control register 3 byte
	input  wire logic [5:0] TABLE_ONE_ROW_I,     // Manual row for table one
	input  wire logic [5:0] TABLE_TWO_ROW_I,     // Manual row for table two
	input  wire logic [7:0] TABLE_ONE_DATA_I,    // Selected table one byte
	input  wire logic [7:0] TABLE_TWO_DATA_I,    // Selected table two byte
	input  wire logic       PERSIST_SEL_I,  // Control register 0 persist select
	input  wire logic       GEN1_DIR_I,     // Generator 1 direction
	output logic      [7:0] RDATA_O,        // Read data
	output logic            ACK_O,          // Data byte acknowledge
	output logic      [7:0] TABLE_ONE_ADDR_O,    // Table one row address
	output logic      [7:0] TABLE_TWO_ADDR_O,    // Table two row address
	output logic      [7:0] DAC1_IN_O,      // Converter 1 input
	output logic      [7:0] DAC2_IN_O,      // Converter 2 input
	output logic      [1:0] GEN1_FS_O,      // Generator 1 range
	output logic      [1:0] GEN2_FS_O,      // Generator 2 range
	output logic            GEN1_DIR_O,     // Generator 1 direction
	output logic            DAC2_PERSIST_O, // 84h kept non-volatile
	output logic            SRC_NV_SAVE_O,  // Pulse: store 85h
	output logic            WEL_O           // Write enable latch
);
	logic [7:0] dac2_code_r, dac2_code_nxt;
	logic [7:0] src_r, src_nxt;
	logic       wel_r, wel_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       ack_r, ack_nxt;
	logic [7:0] l1a_r, l1a_nxt, l2a_r, l2a_nxt;
	logic [7:0] d1_r, d1_nxt, d2_r, d2_nxt;
	logic       dir_r, pers_r, save_r, save_nxt;
	logic [7:0] adc_s1_r, adc_s2_r, adc_s3_r, adc_r, adc_nxt;
	logic [5:0] row1, row2;

	always_comb begin
		dac2_code_nxt = dac2_code_r;
		src_nxt       = src_r;
		wel_nxt       = wel_r;
		ack_nxt       = 1'b0;
		save_nxt      = 1'b0;
		rdata_nxt     = rdata_r;
		if (WR_I) begin
			if (ADDR_I == lds_pkg::ADDR_WR_PERMIT) begin
				ack_nxt = 1'b1;
				if (WDATA_I == lds_pkg::WEL_SET_VAL)
					wel_nxt = 1'b1;
				else if (WDATA_I == lds_pkg::WEL_CLR_VAL)
					wel_nxt = 1'b0;
			end else if (wel_r) begin
				ack_nxt = 1'b1;
				case (ADDR_I)
					lds_pkg::ADDR_DAC2_CODE: dac2_code_nxt = WDATA_I;
					lds_pkg::ADDR_SRC_RANGE: begin
						src_nxt  = WDATA_I;
						save_nxt = 1'b1;
					end
					default: ack_nxt = 1'b1;
				endcase
			end
		end
		if (RD_I) begin
			case (ADDR_I)
				lds_pkg::ADDR_DAC2_CODE:   rdata_nxt = dac2_code_r;
				lds_pkg::ADDR_SRC_RANGE:   rdata_nxt = src_r;
				lds_pkg::ADDR_WR_PERMIT:   rdata_nxt = {wel_r, 7'h00};
				lds_pkg::ADDR_CONV_RESULT: rdata_nxt = adc_r;
				default:                   rdata_nxt = 8'h00;
			endcase
		end
	end

	// Result word taken only once two synced samples agree
	always_comb begin
		adc_nxt = adc_r;
		if (adc_s2_r == adc_s3_r)
			adc_nxt = adc_s3_r;
	end

	always_comb begin
		row1 = src_r[lds_pkg::BIT_TABLE_ONE_SRC] ? TABLE_ONE_ROW_I : adc_r[7:2];
		row2 = src_r[lds_pkg::BIT_TABLE_TWO_SRC] ? TABLE_TWO_ROW_I : adc_r[7:2];
		l1a_nxt = lds_pkg::TABLE_ONE_BASE + {2'h0, row1};
		l2a_nxt = lds_pkg::TABLE_TWO_BASE + {2'h0, row2};
		d1_nxt = src_r[lds_pkg::BIT_DAC1_SRC] ? DAC1_CODE_I
		                                      : TABLE_ONE_DATA_I;
		d2_nxt = src_r[lds_pkg::BIT_DAC2_SRC] ? dac2_code_r
		                                      : TABLE_TWO_DATA_I;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dac2_code_r <= lds_pkg::RST_DAC2_CODE;
			src_r       <= lds_pkg::RST_SRC_RANGE;
			wel_r       <= lds_pkg::RST_WEL;
			rdata_r     <= 8'h00;
			ack_r       <= 1'b0;
			save_r      <= 1'b0;
			l1a_r       <= lds_pkg::TABLE_ONE_BASE;
			l2a_r       <= lds_pkg::TABLE_TWO_BASE;
			d1_r        <= 8'h00;
			d2_r        <= 8'h00;
			dir_r       <= 1'b0;
			pers_r      <= 1'b0;
			adc_s1_r    <= 8'h00;
			adc_s2_r    <= 8'h00;
			adc_s3_r    <= 8'h00;
			adc_r       <= 8'h00;
		end else begin
			dac2_code_r <= dac2_code_nxt;
			src_r       <= src_nxt;
			wel_r       <= wel_nxt;
			rdata_r     <= rdata_nxt;
			ack_r       <= ack_nxt;
			save_r      <= save_nxt;
			l1a_r       <= l1a_nxt;
			l2a_r       <= l2a_nxt;
			d1_r        <= d1_nxt;
			d2_r        <= d2_nxt;
			dir_r       <= GEN1_DIR_I;
			pers_r      <= PERSIST_SEL_I;
			adc_s1_r    <= ADC_I;
			adc_s2_r    <= adc_s1_r;
			adc_s3_r    <= adc_s2_r;
			adc_r       <= adc_nxt;
		end
	end

	assign RDATA_O        = rdata_r;
	assign ACK_O          = ack_r;
	assign TABLE_ONE_ADDR_O    = l1a_r;
	assign TABLE_TWO_ADDR_O    = l2a_r;
	assign DAC1_IN_O      = d1_r;
	assign DAC2_IN_O      = d2_r;
	assign GEN1_FS_O      = src_r[lds_pkg::BIT_GEN1_FS_LO +: 2];
	assign GEN2_FS_O      = src_r[lds_pkg::BIT_GEN2_FS_LO +: 2];
	assign GEN1_DIR_O     = dir_r;
	assign DAC2_PERSIST_O = pers_r;
	assign SRC_NV_SAVE_O  = save_r;
	assign WEL_O          = wel_r;

	a_wel_gate: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(WR_I && !wel_r && ADDR_I != lds_pkg::ADDR_WR_PERMIT) |=> !ACK_O)
		else $error("write acked with latch clear");
	a_dac2_lock: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!(WR_I && wel_r && ADDR_I == lds_pkg::ADDR_DAC2_CODE)
		|=> $stable(dac2_code_r))
		else $error("direct code changed without write");
	a_wel_set: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(WR_I && ADDR_I == lds_pkg::ADDR_WR_PERMIT
		 && WDATA_I == lds_pkg::WEL_SET_VAL) |=> WEL_O)
		else $error("latch not set");
	a_wel_clr: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(WR_I && ADDR_I == lds_pkg::ADDR_WR_PERMIT
		 && WDATA_I == lds_pkg::WEL_CLR_VAL) |=> !WEL_O)
		else $error("latch not cleared");
	a_wel_hold: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!(WR_I && ADDR_I == lds_pkg::ADDR_WR_PERMIT) |=> $stable(WEL_O))
		else $error("latch changed without write");
	a_rsvd_zero: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(RD_I && ADDR_I == lds_pkg::ADDR_WR_PERMIT) |=> RDATA_O[6:0] == 7'h00)
		else $error("reserved bits not zero");
	a_src_hold: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!(WR_I && wel_r) |=> $stable(src_r))
		else $error("select byte changed without write");
	a_nv_save: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(WR_I && wel_r && ADDR_I == lds_pkg::ADDR_SRC_RANGE)
		|=> SRC_NV_SAVE_O)
		else $error("store pulse missing");
	a_dac2_sel: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_DAC2_SRC] |=> DAC2_IN_O == $past(dac2_code_r))
		else $error("converter 2 not on direct code");
	a_dac2_lut: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!src_r[lds_pkg::BIT_DAC2_SRC] |=> DAC2_IN_O == $past(TABLE_TWO_DATA_I))
		else $error("converter 2 not on table row");
	a_table_one_row: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_TABLE_ONE_SRC]
		|=> TABLE_ONE_ADDR_O == lds_pkg::TABLE_ONE_BASE + {2'h0, $past(TABLE_ONE_ROW_I)})
		else $error("table one manual row wrong");
	a_table_two_addr: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!src_r[lds_pkg::BIT_TABLE_TWO_SRC]
		|=> TABLE_TWO_ADDR_O == lds_pkg::TABLE_TWO_BASE + {2'h0, $past(adc_r[7:2])})
		else $error("table two address wrong");
	a_table_two_row: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_TABLE_TWO_SRC]
		|=> TABLE_TWO_ADDR_O == lds_pkg::TABLE_TWO_BASE + {2'h0, $past(TABLE_TWO_ROW_I)})
		else $error("table two manual row wrong");
	a_dac1_sel: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		!src_r[lds_pkg::BIT_DAC1_SRC] |=> DAC1_IN_O == $past(TABLE_ONE_DATA_I))
		else $error("converter 1 not on table row");
	a_dac1_direct: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_DAC1_SRC] |=> DAC1_IN_O == $past(DAC1_CODE_I))
		else $error("converter 1 not on direct byte");
	a_adc_read: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		(RD_I && ADDR_I == lds_pkg::ADDR_CONV_RESULT)
		|=> RDATA_O == $past(adc_r))
		else $error("result read wrong");
	c_wel_write: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		WEL_O ##1 (WR_I && ADDR_I == lds_pkg::ADDR_SRC_RANGE) ##1 ACK_O);
	c_abort: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		!WEL_O && WR_I && ADDR_I == lds_pkg::ADDR_DAC2_CODE);
	c_direct: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_DAC2_SRC] && src_r[lds_pkg::BIT_TABLE_ONE_SRC]);
	c_manual_rows: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		src_r[lds_pkg::BIT_TABLE_ONE_SRC] && src_r[lds_pkg::BIT_TABLE_TWO_SRC]);
endmodule // lds_regs

/* File: lds_lut_model.sv */
// Table memory model answering row addresses with address-tied bytes
`timescale 1ns/1ps
module lds_lut_model (
	input  wire logic [7:0] TABLE_ONE_ADDR_I, // Table one address
	input  wire logic [7:0] TABLE_TWO_ADDR_I, // Table two address
	output logic      [7:0] TABLE_ONE_DATA_O, // Table one byte
	output logic      [7:0] TABLE_TWO_DATA_O  // Table two byte
);
	// Byte tied to its address so a wrong row shows
	assign TABLE_ONE_DATA_O = ~TABLE_ONE_ADDR_I;
	assign TABLE_TWO_DATA_O = ~TABLE_TWO_ADDR_I;
endmodule // lds_lut_model

/* File: lds_regs_tb.sv */
// Self-checking bench of the source control bank
`timescale 1ns/1ps
module lds_regs_tb;
	logic       clk   = 1'b0;
	logic       rst_n = 1'b0;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] adc   = 8'hB7;
	logic [7:0] dac1  = 8'h5A;
	logic [5:0] row1  = 6'h15;
	logic [5:0] row2  = 6'h2A;
	logic       pers  = 1'b0;
	logic       dir   = 1'b0;
	logic [7:0] l1a, l2a, l1d, l2d, rdata, d1, d2;
	logic [1:0] fs1, fs2;
	logic       ack, gdir, dpers, nvs, write_enable_latch;
	int         failures    = 0;
	int         checks_done = 0;
	always #2.5 clk = ~clk;
	lds_regs uut (.CLK_I(clk), .RESETN_I(rst_n), .WR_I(wr), .RD_I(rd),
		.ADDR_I(addr), .WDATA_I(wdata), .ADC_I(adc), .DAC1_CODE_I(dac1),
		.TABLE_ONE_ROW_I(row1), .TABLE_TWO_ROW_I(row2), .TABLE_ONE_DATA_I(l1d),
		.TABLE_TWO_DATA_I(l2d), .PERSIST_SEL_I(pers), .GEN1_DIR_I(dir),
		.RDATA_O(rdata), .ACK_O(ack), .TABLE_ONE_ADDR_O(l1a), .TABLE_TWO_ADDR_O(l2a),
		.DAC1_IN_O(d1), .DAC2_IN_O(d2), .GEN1_FS_O(fs1), .GEN2_FS_O(fs2),
		.GEN1_DIR_O(gdir), .DAC2_PERSIST_O(dpers), .SRC_NV_SAVE_O(nvs),
		.WEL_O(write_enable_latch));
	lds_lut_model model (.TABLE_ONE_ADDR_I(l1a), .TABLE_TWO_ADDR_I(l2a),
		.TABLE_ONE_DATA_O(l1d), .TABLE_TWO_DATA_O(l2d));
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrb(logic [7:0] a, logic [7:0] d, logic e);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
		chk("ack", e, ack);
		chk("nv_save", e && a == 8'h85, nvs);
	endtask
	task automatic rdb(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("wel", 0, write_enable_latch);
		chk("table_one_addr", 8'h90, l1a);
		chk("table_two_addr", 8'hD0, l2a);
		wrb(8'h84, 8'h3C, 0);
		rdb(8'h84, 8'h00);
		$display("test reset_and_lock done");
		wrb(8'h86, 8'h80, 1);
		chk("wel", 1, write_enable_latch);
		rdb(8'h86, 8'h80);
		wrb(8'h84, 8'h3C, 1);
		rdb(8'h84, 8'h3C);
		for (int i = 0; i < 4; i++) begin
			wrb(8'h85, {4'hF, i[1:0], i[1:0]}, 1);
			settle();
			chk("gen1_fs", i, fs1);
			chk("gen2_fs", i, fs2);
		end
		chk("dac2_in", 8'h3C, d2);
		chk("dac1_in", 8'h5A, d1);
		chk("table_one_addr", 8'hA5, l1a);
		chk("table_two_addr", 8'hFA, l2a);
		rdb(8'h85, 8'hFF);
		wrb(8'h85, 8'h00, 1);
		settle();
		chk("table_one_addr", 8'hBD, l1a);
		chk("table_two_addr", 8'hFD, l2a);
		chk("dac1_in", 8'h42, d1);
		chk("dac2_in", 8'h02, d2);
		$display("test source_select done");
		rdb(8'h87, 8'hB7);
		wrb(8'h87, 8'h00, 1);
		rdb(8'h87, 8'hB7);
		wrb(8'h88, 8'h55, 1);
		rdb(8'h88, 8'h00);
		rdb(8'h8F, 8'h00);
		@(posedge clk);
		dir <= 1'b1;
		pers <= 1'b1;
		settle();
		chk("gen1_dir", 1, gdir);
		chk("dac2_persist", 1, dpers);
		$display("test status_reserved done");
		wrb(8'h86, 8'h81, 1);
		chk("wel", 1, write_enable_latch);
		wrb(8'h86, 8'h00, 1);
		chk("wel", 0, write_enable_latch);
		wrb(8'h85, 8'hFF, 0);
		rdb(8'h85, 8'h00);
		$display("test latch_clear done");
		end_of_test();
	end
endmodule // lds_regs_tb
